/* verilog/lcdcfg_ctrl.sv */
// segment lcd configuration and enable control with avalon-mm register slave
// Behaviour
// - display driven only once module enable set
// - reference select: 0 doubler, 1 tripler
// - bypass bit: 0 buffered, 1 unbuffered
// - supply code 10 means external lcd supply
// - wait disable low keeps display in wait
// - stop disable low keeps display in stop
// - interrupt enable low blocks frame_irq_o only; irq_o frame source follows the irq mask
// - regulator enable and trim; level output follows the reference select bit
// - three-bit duty and frame divider fields
// - blink alternate, blank, mode and rate
// - 64 pin enables and 64 backplane enables
// - reset clears enable, quarter duty, third bias
// - frame flag sticky, write one clears, interrupts
`include "lcdcfg_cfg.svh"
module lcdcfg_ctrl #(
  parameter int FRAME_BASE = `LCDCFG_FRAME_BASE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic waitrequest_o,
  output logic [31:0] readdata_o,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  output logic irq_o,
  output logic frame_irq_o,
  output logic driving_o,
  output logic [63:0] pin_oe_o,
  output logic [63:0] backplane_o,
  output logic clk_src_o,
  output logic [2:0] duty_o,
  output logic [2:0] frame_div_o,
  output logic bias_third_o,
  output logic pump_enable_o,
  output logic pump_tripler_o,
  output logic [1:0] pump_adjust_o,
  output logic buffer_bypass_o,
  output logic [1:0] supply_sel_o,
  output logic ext_supply_o,
  output logic reg_enable_o,
  output logic reg_level_high_o,
  output logic [3:0] reg_trim_o,
  output logic blink_en_o,
  output logic alt_o,
  output logic blank_o,
  output logic blink_mode_o,
  output logic [2:0] blink_rate_o
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic word_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  function automatic lcdcfg_pkg::lcdcfg_word_t merge(input lcdcfg_pkg::lcdcfg_word_t old,
      input lcdcfg_pkg::lcdcfg_word_t wd, input logic [3:0] be);
    lcdcfg_pkg::lcdcfg_word_t m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ****************************************
  // registers
  // ****************************************
  lcdcfg_pkg::lcdcfg_byte_t c0_reg, c1_reg, rv_reg, su_reg, bl_reg;
  logic [63:0] pen_reg, backplane_enable_bits_reg;
  lcdcfg_pkg::lcdcfg_word_t wave_reg [16];
  logic flag_reg;
  logic [1:0] irq_stat_reg, irq_mask_reg;
  logic waitrequest_reg, ext_supply_reg, driving_reg, irq_reg, frame_irq_reg;
  logic bias_third_reg;
  lcdcfg_pkg::lcdcfg_word_t readdata_reg;
  logic [63:0] pin_oe_reg, backplane_reg;
  logic frame_tick;

  // ****************************************
  // bus decode
  // ****************************************
  // a request waits exactly one cycle; the write lands one edge after the wait ends, when waitrequest is sampled low
  wire req = read_i | write_i;
  wire accept = ce_i & req & waitrequest_reg;
  wire wr_fire = ce_i & write_i & ~waitrequest_reg;
  wire rd_fire = ce_i & read_i & ~waitrequest_reg;
  wire lane0 = byteenable_i[0];
  wire hit_c0 = word_hit(address_i, `LCDCFG_OFF_CTRL0);
  wire hit_c1 = word_hit(address_i, `LCDCFG_OFF_CTRL1);
  wire hit_rv = word_hit(address_i, `LCDCFG_OFF_REGUL);
  wire hit_su = word_hit(address_i, `LCDCFG_OFF_SUPPLY);
  wire hit_bl = word_hit(address_i, `LCDCFG_OFF_BLINK);
  wire hit_st = word_hit(address_i, `LCDCFG_OFF_STATUS);
  wire hit_is = word_hit(address_i, `LCDCFG_OFF_IRQ_STAT);
  wire hit_im = word_hit(address_i, `LCDCFG_OFF_IRQ_MASK);
  wire hit_pl = word_hit(address_i, `LCDCFG_OFF_PEN_LO);
  wire hit_ph = word_hit(address_i, `LCDCFG_OFF_PEN_HI);
  wire hit_bpl = word_hit(address_i, `LCDCFG_OFF_BACKPLANE_ENABLE_BITS_LO);
  wire hit_bph = word_hit(address_i, `LCDCFG_OFF_BACKPLANE_ENABLE_BITS_HI);
  wire hit_wave = (address_i[7:6] == 2'(`LCDCFG_OFF_WAVE >> 6));
  wire [3:0] wave_idx = address_i[5:2];
  wire wr8 = wr_fire & lane0;
  wire [7:0] wd8 = writedata_i[7:0];

  // unmapped addresses read as zero and ignore writes
  wire [31:0] rd_value =
    hit_c0 ? {24'h000000, c0_reg} :
    hit_c1 ? {24'h000000, c1_reg} :
    hit_rv ? {24'h000000, rv_reg} :
    hit_su ? {24'h000000, su_reg} :
    hit_bl ? {24'h000000, bl_reg} :
    hit_st ? {31'h00000000, flag_reg} :
    hit_is ? {30'h00000000, irq_stat_reg} :
    hit_im ? {30'h00000000, irq_mask_reg} :
    hit_pl ? pen_reg[31:0] :
    hit_ph ? pen_reg[63:32] :
    hit_bpl ? backplane_enable_bits_reg[31:0] :
    hit_bph ? backplane_enable_bits_reg[63:32] :
    hit_wave ? wave_reg[wave_idx] : 32'h00000000;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else if (ce_i) begin
      waitrequest_reg <= ~accept;
      if (accept) begin
        readdata_reg <= read_i ? rd_value : 32'h00000000;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  wire [7:0] c0_next = (wr8 & hit_c0) ? (wd8 & `LCDCFG_MASK_C0) : c0_reg;
  wire [7:0] c1_next = (wr8 & hit_c1) ? (wd8 & `LCDCFG_MASK_C1) : c1_reg;
  wire [7:0] rv_next = (wr8 & hit_rv) ? (wd8 & `LCDCFG_MASK_RV) : rv_reg;
  wire [7:0] su_next = (wr8 & hit_su) ? (wd8 & `LCDCFG_MASK_SU) : su_reg;
  wire [7:0] bl_next = (wr8 & hit_bl) ? (wd8 & `LCDCFG_MASK_BL) : bl_reg;

  // enable cleared and quarter duty at reset; no clocked path sets enable itself
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c0_reg <= `LCDCFG_RST_C0;
      c1_reg <= `LCDCFG_RST_C1;
      rv_reg <= `LCDCFG_RST_RV;
      su_reg <= `LCDCFG_RST_SU;
      bl_reg <= `LCDCFG_RST_BL;
      bias_third_reg <= 1'b1;
    end else if (ce_i) begin
      c0_reg <= c0_next;
      c1_reg <= c1_next;
      rv_reg <= rv_next;
      su_reg <= su_next;
      bl_reg <= bl_next;
      bias_third_reg <= 1'b1;
    end
  end

  // pin banks are cleared here, but software still owns their contents
  wire [63:0] pen_next = {hit_ph & wr_fire ? merge(pen_reg[63:32], writedata_i, byteenable_i)
                                           : pen_reg[63:32],
                          hit_pl & wr_fire ? merge(pen_reg[31:0], writedata_i, byteenable_i)
                                           : pen_reg[31:0]};
  wire [63:0] backplane_enable_bits_next = {hit_bph & wr_fire ? merge(backplane_enable_bits_reg[63:32], writedata_i, byteenable_i)
                                             : backplane_enable_bits_reg[63:32],
                           hit_bpl & wr_fire ? merge(backplane_enable_bits_reg[31:0], writedata_i, byteenable_i)
                                             : backplane_enable_bits_reg[31:0]};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pen_reg <= 64'h0000000000000000;
      backplane_enable_bits_reg <= 64'h0000000000000000;
    end else if (ce_i) begin
      pen_reg <= pen_next;
      backplane_enable_bits_reg <= backplane_enable_bits_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gen_wave
      wire wave_wr = wr_fire & hit_wave & (wave_idx == 4'(g));
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          wave_reg[g] <= 32'h00000000;
        end else if (ce_i && wave_wr) begin
          wave_reg[g] <= merge(wave_reg[g], writedata_i, byteenable_i);
        end
      end
    end
  endgenerate

  // ****************************************
  // drive control
  // ****************************************
  wire wait_block = wait_mode_i & c1_reg[`LCDCFG_C1_WDIS];
  wire stop_block = stop_mode_i & c1_reg[`LCDCFG_C1_SDIS];
  wire drive_now = c0_reg[`LCDCFG_C0_EN] & ~wait_block & ~stop_block;
  wire ext_code = su_reg[`LCDCFG_SU_SEL_LSB +: 2] == lcdcfg_pkg::LCDCFG_SUP_EXT_LCD;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      driving_reg <= 1'b0;
      pin_oe_reg <= 64'h0000000000000000;
      backplane_reg <= 64'h0000000000000000;
      ext_supply_reg <= 1'b0;
    end else if (ce_i) begin
      driving_reg <= drive_now;
      pin_oe_reg <= drive_now ? pen_reg : 64'h0000000000000000;
      backplane_reg <= drive_now ? (pen_reg & backplane_enable_bits_reg) : 64'h0000000000000000;
      ext_supply_reg <= ext_code;
    end
  end

  lcdcfg_frame_timer #(
    .BASE_CYCLES(FRAME_BASE)
  ) u_frame (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(driving_reg),
    .div_i(c0_reg[`LCDCFG_C0_DIV_LSB +: 3]),
    .frame_o(frame_tick)
  );

  // ****************************************
  // flags and interrupts
  // ****************************************
  // a new frame event wins over a clear in the same cycle
  wire flag_clr = wr8 & hit_st & wd8[`LCDCFG_ST_FLAG];
  wire flag_next = frame_tick | (flag_reg & ~flag_clr);
  wire start_evt = drive_now & ~driving_reg;
  wire [1:0] irq_events = {start_evt, frame_tick};
  // only bits that were captured for the reader are cleared by the read
  wire [1:0] irq_clr = (rd_fire & hit_is) ? readdata_reg[1:0] : 2'b00;
  wire [1:0] irq_stat_next = irq_events | (irq_stat_reg & ~irq_clr);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
      irq_stat_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
      irq_reg <= 1'b0;
      frame_irq_reg <= 1'b0;
    end else if (ce_i) begin
      flag_reg <= flag_next;
      irq_stat_reg <= irq_stat_next;
      if (wr8 && hit_im) begin
        irq_mask_reg <= wd8[1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
      frame_irq_reg <= flag_reg & c1_reg[`LCDCFG_C1_IEN];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign waitrequest_o = waitrequest_reg;
  assign readdata_o = readdata_reg;
  assign irq_o = irq_reg;
  assign frame_irq_o = frame_irq_reg;
  assign driving_o = driving_reg;
  assign pin_oe_o = pin_oe_reg;
  assign backplane_o = backplane_reg;
  assign clk_src_o = c0_reg[`LCDCFG_C0_SRC];
  assign duty_o = c0_reg[`LCDCFG_C0_DUTY_LSB +: 3];
  assign frame_div_o = c0_reg[`LCDCFG_C0_DIV_LSB +: 3];
  assign bias_third_o = bias_third_reg;
  assign pump_enable_o = su_reg[`LCDCFG_SU_CP];
  assign pump_tripler_o = su_reg[`LCDCFG_SU_REF];
  assign pump_adjust_o = su_reg[`LCDCFG_SU_ADJ_LSB +: 2];
  assign buffer_bypass_o = su_reg[`LCDCFG_SU_BYP];
  assign supply_sel_o = su_reg[`LCDCFG_SU_SEL_LSB +: 2];
  assign ext_supply_o = ext_supply_reg;
  assign reg_enable_o = rv_reg[`LCDCFG_RV_EN];
  assign reg_level_high_o = su_reg[`LCDCFG_SU_REF];
  assign reg_trim_o = rv_reg[`LCDCFG_RV_TRIM_LSB +: 4];
  assign blink_en_o = bl_reg[`LCDCFG_BL_EN];
  assign alt_o = bl_reg[`LCDCFG_BL_ALT];
  assign blank_o = bl_reg[`LCDCFG_BL_BLANK];
  assign blink_mode_o = bl_reg[`LCDCFG_BL_MODE];
  assign blink_rate_o = bl_reg[`LCDCFG_BL_RATE_LSB +: 3];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_bus_wait_once: assert property (ce_i && req && waitrequest_o |=> !waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_bus_release: assert property (ce_i && !waitrequest_o |=> waitrequest_o)
    else $error("waitrequest stayed low");
  a_off_tristate: assert property (
      ce_i && !c0_reg[`LCDCFG_C0_EN] |=> pin_oe_o == 64'h0 && !driving_o)
    else $error("pins driven while module disabled");
  a_pins_follow: assert property (ce_i && drive_now |=> pin_oe_o == $past(pen_reg))
    else $error("pin enables not passed while driving");
  a_bp_subset: assert property ((backplane_o & ~pin_oe_o) == 64'h0)
    else $error("backplane on a disabled pin");
  a_wait_keeps: assert property (
      ce_i && c0_reg[`LCDCFG_C0_EN] && wait_mode_i && !stop_block && !c1_reg[`LCDCFG_C1_WDIS]
      |=> driving_o)
    else $error("display stopped in wait with wait disable low");
  a_stop_keeps: assert property (
      ce_i && c0_reg[`LCDCFG_C0_EN] && stop_mode_i && !wait_block && !c1_reg[`LCDCFG_C1_SDIS]
      |=> driving_o)
    else $error("display stopped in stop with stop disable low");
  a_irq_gated: assert property (ce_i && !c1_reg[`LCDCFG_C1_IEN] |=> !frame_irq_o)
    else $error("frame interrupt while disabled");
  a_flag_sticky: assert property (ce_i && flag_reg && !flag_clr |=> flag_reg)
    else $error("frame flag dropped without clear");
  a_pump_mode: assert property (
      wr8 && hit_su |=> pump_tripler_o == $past(wd8[`LCDCFG_SU_REF])
      && buffer_bypass_o == $past(wd8[`LCDCFG_SU_BYP]))
    else $error("pump or buffer mode not taken from write");
  a_ext_supply: assert property (wr8 && hit_su && wd8[1:0] == 2'b10 |=> ##1 ext_supply_o)
    else $error("external supply not flagged");

  c_enable_write: cover property (wr8 && hit_c0 && wd8[`LCDCFG_C0_EN]);
  c_frame_irq: cover property (!frame_irq_o ##1 frame_irq_o);
  c_irq_out: cover property (irq_o);
  c_wait_drive: cover property (wait_mode_i && driving_o);
endmodule

/* verilog/lcdcfg_cfg.svh */
// register offsets, field positions and reset values of the lcd configuration block
`ifndef LCDCFG_CFG_SVH
`define LCDCFG_CFG_SVH

// ****************************************
// byte offsets
// ****************************************
`define LCDCFG_OFF_CTRL0 8'h00
`define LCDCFG_OFF_CTRL1 8'h04
`define LCDCFG_OFF_REGUL 8'h08
`define LCDCFG_OFF_SUPPLY 8'h0c
`define LCDCFG_OFF_BLINK 8'h10
`define LCDCFG_OFF_STATUS 8'h14
`define LCDCFG_OFF_IRQ_STAT 8'h18
`define LCDCFG_OFF_IRQ_MASK 8'h1c
`define LCDCFG_OFF_PEN_LO 8'h20
`define LCDCFG_OFF_PEN_HI 8'h24
`define LCDCFG_OFF_BACKPLANE_ENABLE_BITS_LO 8'h28
`define LCDCFG_OFF_BACKPLANE_ENABLE_BITS_HI 8'h2c
`define LCDCFG_OFF_WAVE 8'h40

// ****************************************
// field positions
// ****************************************
`define LCDCFG_C0_EN 7
`define LCDCFG_C0_SRC 6
`define LCDCFG_C0_DIV_LSB 3
`define LCDCFG_C0_DUTY_LSB 0
`define LCDCFG_C1_IEN 7
`define LCDCFG_C1_WDIS 1
`define LCDCFG_C1_SDIS 0
`define LCDCFG_RV_EN 7
`define LCDCFG_RV_TRIM_LSB 0
`define LCDCFG_SU_CP 7
`define LCDCFG_SU_REF 6
`define LCDCFG_SU_ADJ_LSB 4
`define LCDCFG_SU_BYP 3
`define LCDCFG_SU_SEL_LSB 0
`define LCDCFG_BL_EN 7
`define LCDCFG_BL_ALT 6
`define LCDCFG_BL_BLANK 5
`define LCDCFG_BL_MODE 3
`define LCDCFG_BL_RATE_LSB 0
`define LCDCFG_ST_FLAG 0
`define LCDCFG_IRQ_FRAME 0
`define LCDCFG_IRQ_START 1

// ****************************************
// writable masks and reset values
// ****************************************
`define LCDCFG_MASK_C0 8'hff
`define LCDCFG_MASK_C1 8'h83
`define LCDCFG_MASK_RV 8'h8f
`define LCDCFG_MASK_SU 8'hfb
`define LCDCFG_MASK_BL 8'hef
`define LCDCFG_RST_C0 8'h03
`define LCDCFG_RST_C1 8'h00
`define LCDCFG_RST_RV 8'h00
`define LCDCFG_RST_SU 8'h00
`define LCDCFG_RST_BL 8'h00
`define LCDCFG_FRAME_BASE 256

`endif

/* verilog/lcdcfg_pkg.sv */
// types shared by the lcd configuration block
package lcdcfg_pkg;
  typedef logic [31:0] lcdcfg_word_t;
  typedef logic [7:0] lcdcfg_byte_t;
  typedef enum logic [1:0] {
    LCDCFG_SUP_VDD_MID = 2'b00,
    LCDCFG_SUP_VDD_TOP = 2'b01,
    LCDCFG_SUP_EXT_LCD = 2'b10,
    LCDCFG_SUP_EXT_ALL = 2'b11
  } lcdcfg_supply_t;
endpackage

/* verilog/lcdcfg_frame_timer.sv */
// frame event timer: one pulse per frame while the display is driven
`include "lcdcfg_cfg.svh"
module lcdcfg_frame_timer #(
  parameter int BASE_CYCLES = `LCDCFG_FRAME_BASE,
  parameter int CNT_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [2:0] div_i,
  output logic frame_o
);
  // ****************************************
  // period = base * (divider + 1)
  // ****************************************
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic frame_next;
  wire [CNT_W-1:0] base_w = CNT_W'(BASE_CYCLES);
  wire [CNT_W-1:0] limit_w = CNT_W'(base_w * ({{(CNT_W-3){1'b0}}, div_i} + 1'b1) - 1'b1);
  wire at_end = (cnt_reg >= limit_w);

  // a stopped display restarts its frame from zero
  assign cnt_next = !run_i ? '0 : (at_end ? '0 : cnt_reg + 1'b1);
  assign frame_next = run_i & at_end;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      frame_o <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      frame_o <= frame_next;
    end
  end
endmodule

/* test/lcdcfg_glass.sv */
// lcd glass model: watches which pins drive frontplanes and backplanes
module lcdcfg_glass (
  input wire logic [63:0] pin_oe_i,
  input wire logic [63:0] backplane_i,
  output logic bad_o,
  output int n_back_o,
  output int n_front_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // plane bookkeeping
  // ****
  // a backplane on an undriven pin would leave a common plane floating
  assign bad_o = |(backplane_i & ~pin_oe_i);
  assign n_back_o = $countones(backplane_i);
  assign n_front_o = $countones(pin_oe_i & ~backplane_i);
endmodule

/* test/lcdcfg_ctrl_test.sv */
// self-checking bench of the lcd configuration block
`include "lcdcfg_cfg.svh"
module lcdcfg_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  // small frame base keeps the frame events a few cycles apart
  localparam int FB = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0] byteenable_i = 4'hf;
  logic wait_mode_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic waitrequest_o, irq_o, frame_irq_o, driving_o, clk_src_o, bias_third_o;
  logic pump_enable_o, pump_tripler_o, buffer_bypass_o, ext_supply_o, reg_enable_o;
  logic reg_level_high_o, blink_en_o, alt_o, blank_o, blink_mode_o, g_bad;
  logic [31:0] readdata_o;
  logic [63:0] pin_oe_o, backplane_o;
  logic [2:0] duty_o, frame_div_o, blink_rate_o;
  logic [1:0] pump_adjust_o, supply_sel_o;
  logic [3:0] reg_trim_o;
  int g_back, g_front;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] lfsr_state = 32'h00000015;
  logic [31:0] model [int];
  logic [7:0] offs [5] = '{`LCDCFG_OFF_CTRL0, `LCDCFG_OFF_REGUL, `LCDCFG_OFF_SUPPLY,
    `LCDCFG_OFF_CTRL1, `LCDCFG_OFF_BLINK};
  logic [7:0] msks [5] = '{`LCDCFG_MASK_C0, `LCDCFG_MASK_RV, `LCDCFG_MASK_SU,
    `LCDCFG_MASK_C1, `LCDCFG_MASK_BL};

  lcdcfg_ctrl #(.FRAME_BASE(FB)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .waitrequest_o(waitrequest_o), .readdata_o(readdata_o), .wait_mode_i(wait_mode_i),
    .stop_mode_i(stop_mode_i), .irq_o(irq_o), .frame_irq_o(frame_irq_o),
    .driving_o(driving_o), .pin_oe_o(pin_oe_o), .backplane_o(backplane_o),
    .clk_src_o(clk_src_o), .duty_o(duty_o), .frame_div_o(frame_div_o),
    .bias_third_o(bias_third_o), .pump_enable_o(pump_enable_o),
    .pump_tripler_o(pump_tripler_o), .pump_adjust_o(pump_adjust_o),
    .buffer_bypass_o(buffer_bypass_o), .supply_sel_o(supply_sel_o),
    .ext_supply_o(ext_supply_o), .reg_enable_o(reg_enable_o),
    .reg_level_high_o(reg_level_high_o), .reg_trim_o(reg_trim_o),
    .blink_en_o(blink_en_o), .alt_o(alt_o), .blank_o(blank_o),
    .blink_mode_o(blink_mode_o), .blink_rate_o(blink_rate_o));

  lcdcfg_glass glass (.pin_oe_i(pin_oe_o), .backplane_i(backplane_o), .bad_o(g_bad),
    .n_back_o(g_back), .n_front_o(g_front));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], 1'b0} ^ (lfsr_state[31] ? 32'h04000007 : 32'h0);
    return lfsr_state;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one request held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    read_i <= !wr_en;
    write_i <= wr_en;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(q, exp);
  endtask

  task automatic mwr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    model[a] = d & m;
    wr(a, d);
  endtask

  task automatic mrd(input logic [7:0] a);
    rd(a, model.exists(a) ? model[a] : 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end

  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] v;
    logic [7:0] c0, su, rv, bl;
    model[`LCDCFG_OFF_CTRL0] = `LCDCFG_RST_C0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(2);
    check({duty_o, bias_third_o, driving_o}, {3'b011, 2'b10});
    check(pin_oe_o, 64'h0);
    for (int i = 0; i < 5; i++) mrd(offs[i]);
    // configuration order with the module held off; code sweeps all supply codes
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 5; i++) begin
        v = rnd();
        if (i == 0) v[7] = 1'b0;
        if (i == 2) v[1:0] = p[1:0];
        mwr(offs[i], v, {24'h0, msks[i]});
      end
      for (int i = 0; i < 5; i++) mrd(offs[i]);
      cyc(3);
      c0 = model[`LCDCFG_OFF_CTRL0][7:0];
      rv = model[`LCDCFG_OFF_REGUL][7:0];
      su = model[`LCDCFG_OFF_SUPPLY][7:0];
      bl = model[`LCDCFG_OFF_BLINK][7:0];
      check({clk_src_o, frame_div_o, duty_o}, c0[6:0]);
      check({pump_enable_o, pump_tripler_o, pump_adjust_o, buffer_bypass_o}, su[7:3]);
      check({supply_sel_o, ext_supply_o}, {su[1:0], su[1:0] == 2'b10});
      check({reg_enable_o, reg_level_high_o, reg_trim_o}, {rv[7], su[6], rv[3:0]});
      check({blink_en_o, alt_o, blank_o, blink_mode_o, blink_rate_o}, {bl[7:5], bl[3:0]});
      check(driving_o, 1'b0);
    end
    bus(1'b1, `LCDCFG_OFF_BLINK, rnd(), 4'he, v);
    mrd(`LCDCFG_OFF_BLINK);
    wr(8'h30, rnd());
    rd(8'h30, 32'h0);
    // every bank is written after reset before the module is enabled
    for (int k = 0; k < 4; k++) mwr(8'h20 + 8'(4 * k), rnd(), 32'hffffffff);
    mwr(8'h40, rnd(), 32'hffffffff);
    mwr(8'h7c, rnd(), 32'hffffffff);
    for (int k = 0; k < 4; k++) mrd(8'h20 + 8'(4 * k));
    mrd(8'h40);
    mrd(8'h7c);
    check(pin_oe_o, 64'h0);
    mwr(`LCDCFG_OFF_CTRL1, 32'h0, `LCDCFG_MASK_C1);
    mwr(`LCDCFG_OFF_CTRL0, 32'h80, `LCDCFG_MASK_C0);
    cyc(2);
    v = model[8'h28] & model[8'h20];
    check(pin_oe_o, {model[8'h24], model[8'h20]});
    check(backplane_o, {model[8'h2c] & model[8'h24], v});
    check({g_bad, 63'(g_back)}, $countones({model[8'h2c] & model[8'h24], v}));
    v = model[8'h20] & ~model[8'h28];
    check(g_front, $countones({model[8'h24] & ~model[8'h2c], v}));
    // frames run with the frame interrupt held off
    cyc(12);
    check(frame_irq_o, 1'b0);
    rd(`LCDCFG_OFF_STATUS, 32'h1);
    wr(`LCDCFG_OFF_STATUS, 32'h0);
    rd(`LCDCFG_OFF_STATUS, 32'h1);
    check(irq_o, 1'b0);
    mwr(`LCDCFG_OFF_IRQ_MASK, 32'h3, 32'h3);
    cyc(3);
    check(irq_o, 1'b1);
    mwr(`LCDCFG_OFF_CTRL1, 32'h80, `LCDCFG_MASK_C1);
    cyc(3);
    check(frame_irq_o, 1'b1);
    wait_mode_i <= 1'b1;
    cyc(3);
    check(driving_o, 1'b1);
    mwr(`LCDCFG_OFF_CTRL1, 32'h82, `LCDCFG_MASK_C1);
    cyc(3);
    check(driving_o, 1'b0);
    check(pin_oe_o, 64'h0);
    wait_mode_i <= 1'b0;
    stop_mode_i <= 1'b1;
    mwr(`LCDCFG_OFF_CTRL1, 32'h80, `LCDCFG_MASK_C1);
    cyc(3);
    check(driving_o, 1'b1);
    mwr(`LCDCFG_OFF_CTRL1, 32'h81, `LCDCFG_MASK_C1);
    cyc(3);
    check(driving_o, 1'b0);
    stop_mode_i <= 1'b0;
    mwr(`LCDCFG_OFF_CTRL0, 32'h0, `LCDCFG_MASK_C0);
    cyc(12);
    check(pin_oe_o, 64'h0);
    rd(`LCDCFG_OFF_IRQ_STAT, 32'h3);
    rd(`LCDCFG_OFF_IRQ_STAT, 32'h0);
    cyc(3);
    check(irq_o, 1'b0);
    wr(`LCDCFG_OFF_STATUS, 32'h1);
    rd(`LCDCFG_OFF_STATUS, 32'h0);
    cyc(3);
    check(frame_irq_o, 1'b0);
    // reset in mid-run while the display is driven
    wr(`LCDCFG_OFF_CTRL0, 32'h80);
    cyc(3);
    rst_i <= 1'b1;
    cyc(2);
    check({driving_o, waitrequest_o, duty_o, bias_third_o}, {2'b01, 3'b011, 1'b1});
    rst_i <= 1'b0;
    cyc(3);
    rd(`LCDCFG_OFF_CTRL0, `LCDCFG_RST_C0);
    check(bias_third_o, 1'b1);
    check(pin_oe_o, 64'h0);
    wrap_up();
  end
endmodule
